// ---- rtl/timer_pair_pkg.sv ----
package timer_pair_pkg;
   // Register indices; the byte address is four times the index.
   localparam logic [7:0] IDX_TB_CONTROL = 8'h88;
   localparam logic [7:0] IDX_TB_READBACK = 8'h89;
   localparam logic [7:0] IDX_TB_LOW = 8'h8c;
   localparam logic [7:0] IDX_TB_HIGH = 8'h8d;
   localparam logic [7:0] IDX_IRQ_CONFIG = 8'ha8;
   localparam logic [7:0] IDX_TA_CONTROL = 8'hc8;
   localparam logic [7:0] IDX_TA_MODE = 8'hc9;
   localparam logic [7:0] IDX_TA_RELOAD_LOW = 8'hca;
   localparam logic [7:0] IDX_TA_RELOAD_HIGH = 8'hcb;
   localparam logic [7:0] IDX_TA_COUNT_LOW = 8'hcc;
   localparam logic [7:0] IDX_TA_COUNT_HIGH = 8'hcd;

   // Timer A control bit positions.
   localparam int TA_FLAG_BIT = 7;
   localparam int TA_EXT_FLAG_BIT = 6;
   localparam int TA_RX_SEL_BIT = 5;
   localparam int TA_TX_SEL_BIT = 4;
   localparam int TA_EXT_EN_BIT = 3;
   localparam int TA_RUN_BIT = 2;
   localparam int TA_CT_SEL_BIT = 1;
   localparam int TA_CAP_SEL_BIT = 0;
   localparam logic [1:0] TA_MODE_MASK = 2'h3;

   // Timer B control bit positions and field codes.
   localparam int TB_FLAG_BIT = 7;
   localparam int TB_PS_LSB = 4;
   localparam int TB_RUN_BIT = 2;
   localparam int TB_CLK_LSB = 0;
   localparam logic [7:0] TB_CONTROL_MASK = 8'hb7;
   localparam logic [1:0] TB_CLK_SYS = 2'h0;
   localparam logic [1:0] TB_CLK_LF = 2'h2;
   localparam logic [1:0] PS_DIV1 = 2'h0;
   localparam logic [1:0] PS_DIV8 = 2'h1;
   localparam logic [1:0] PS_DIV64 = 2'h2;
   localparam logic [7:0] PS_MASK8 = 8'h07;
   localparam logic [7:0] PS_MASK64 = 8'h3f;
   localparam logic [7:0] PS_MASK256 = 8'hff;

   // Interrupt and option configuration bit positions.
   localparam int CFG_GLOBAL_BIT = 7;
   localparam int CFG_TA_IE_BIT = 5;
   localparam int CFG_TB_IE_BIT = 3;
   localparam int CFG_OSC_LSB = 0;
   localparam logic [7:0] CFG_MASK = 8'ha8;

   // Oscillator option codes that provide the low-frequency clock.
   localparam logic [3:0] OSC_OPT_A = 4'ha;
   localparam logic [3:0] OSC_OPT_B = 4'hd;
   localparam logic [3:0] OSC_OPT_C = 4'h3;
   localparam logic [3:0] OSC_OPT_D = 4'h6;

   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [15:0] COUNT_ONE = 16'h0001;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : timer_pair_pkg

// ---- rtl/tick_prescaler.sv ----
`timescale 1ns/10ps
module tick_prescaler
   import timer_pair_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic tick_in,
   input wire logic [1:0] sel,
   output logic tick_out
);
   logic [7:0] div_q;
   logic [7:0] div_d;
   logic [7:0] mask;

   // Terminal count mask for each divide ratio.
   assign mask = (sel == PS_DIV1) ? 8'h00 :
                 (sel == PS_DIV8) ? PS_MASK8 :
                 (sel == PS_DIV64) ? PS_MASK64 : PS_MASK256;
   assign tick_out = tick_in && ((div_q & mask) == mask);
   assign div_d = tick_in ? 8'(div_q + 8'h01) : div_q;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         div_q <= 8'h00;
      end else if (ce) begin
         div_q <= div_d;
      end
   end
endmodule : tick_prescaler

// ---- rtl/dual_reload_timer_pair.sv ----
// Functional notes
// - Timer A counts up by one and flags overflow when passing 0xffff.
// - Each timer A overflow reloads the counter from the reload pair.
// - Overflow flag sets only with both baud selects clear; baud overflows only reload.
// - Timer A flag requests interrupt when global and timer A enables are set.
// - Hardware never clears timer A flag; only software write or reset does.
// - Bit 5 picks receive clock, bit 4 transmit clock; either means baud mode.
// - Baud overflow rate equals system clock over 65536 minus reload value.
// - Control bit 2 starts timer A when one and halts it when zero.
// - Timer B data writes go to hidden reload; reads return live count when readback select is zero.
// - Running timer B counts up, flags overflow and reloads at rollover.
// - Writing timer B high byte copies full reload into the counter.
// - Clock select 00 uses system clock outside power-down; 10 uses low clock on valid options.
// - Prescaler bits 5-4 divide by 1, 8, 64 or 256; the control mask clears bits 6 and 3 on write, so all four ratios can be selected.
// - Timer B flag at bit 7 sets on overflow, cleared by hardware acknowledge.
// - Timer B bit 2 starts and stops counting; selects 01 and 11 are dead.
// - Readback select returns counter when zero and reload when one.
`timescale 1ns/10ps
module dual_reload_timer_pair
   import timer_pair_pkg::*;
(
   input wire logic CLK,
   input wire logic NRST,
   input wire logic CE,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic HREADYOUT,
   output logic [31:0] HRDATA,
   output logic HRESP,
   input wire logic POWER_DOWN,
   input wire logic LF_TICK,
   input wire logic TIMER_B_ACK,
   output logic TIMER_A_IRQ,
   output logic TIMER_B_IRQ,
   output logic RX_BAUD_TICK,
   output logic TX_BAUD_TICK
);
   logic [7:0] ta_ctrl_q;
   logic [7:0] ta_ctrl_d;
   logic [1:0] ta_mode_q;
   logic [1:0] ta_mode_d;
   logic [15:0] ta_reload_q;
   logic [15:0] ta_reload_d;
   logic [15:0] ta_count_q;
   logic [15:0] ta_count_d;
   logic [7:0] tb_ctrl_q;
   logic [7:0] tb_ctrl_d;
   logic [15:0] tb_reload_q;
   logic [15:0] tb_reload_d;
   logic [15:0] tb_count_q;
   logic [15:0] tb_count_d;
   logic tb_readback_q;
   logic tb_readback_d;
   logic [7:0] cfg_q;
   logic [7:0] cfg_d;
   logic [7:0] wr_idx_q;
   logic wr_pend_q;
   logic [31:0] hrdata_q;
   logic [31:0] hrdata_d;
   logic hreadyout_q;
   logic hresp_q;
   logic ta_irq_q;
   logic tb_irq_q;
   logic rx_tick_q;
   logic tx_tick_q;

   // Shared decoding and arithmetic helpers.
   function automatic logic hit(input logic [7:0] idx, input logic [7:0] reg_idx);
      hit = (idx == reg_idx);
   endfunction : hit

   function automatic logic [15:0] inc16(input logic [15:0] v);
      inc16 = 16'(v + COUNT_ONE);
   endfunction : inc16

   function automatic logic at_max(input logic [15:0] v);
      at_max = (v == COUNT_MAX);
   endfunction : at_max

   function automatic logic irq_req(input logic [7:0] cfg, input int ie_bit, input logic flag);
      irq_req = cfg[CFG_GLOBAL_BIT] && cfg[ie_bit] && flag;
   endfunction : irq_req

   function automatic logic osc_valid(input logic [3:0] opt);
      osc_valid = (opt == OSC_OPT_A) || (opt == OSC_OPT_B) || (opt == OSC_OPT_C) ||
                  (opt == OSC_OPT_D);
   endfunction : osc_valid

   // Address phase capture and write strobes for the data phase.
   wire addr_phase = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
   wire [7:0] addr_idx = HADDR[9:2];
   wire [7:0] wdata = HWDATA[7:0];
   wire wr_ta_ctrl = wr_pend_q && hit(wr_idx_q, IDX_TA_CONTROL);
   wire wr_ta_mode = wr_pend_q && hit(wr_idx_q, IDX_TA_MODE);
   wire wr_ta_rl = wr_pend_q && hit(wr_idx_q, IDX_TA_RELOAD_LOW);
   wire wr_ta_rh = wr_pend_q && hit(wr_idx_q, IDX_TA_RELOAD_HIGH);
   wire wr_ta_cl = wr_pend_q && hit(wr_idx_q, IDX_TA_COUNT_LOW);
   wire wr_ta_ch = wr_pend_q && hit(wr_idx_q, IDX_TA_COUNT_HIGH);
   wire wr_tb_ctrl = wr_pend_q && hit(wr_idx_q, IDX_TB_CONTROL);
   wire wr_tb_rb = wr_pend_q && hit(wr_idx_q, IDX_TB_READBACK);
   wire wr_tb_lo = wr_pend_q && hit(wr_idx_q, IDX_TB_LOW);
   wire wr_tb_hi = wr_pend_q && hit(wr_idx_q, IDX_TB_HIGH);
   wire wr_cfg = wr_pend_q && hit(wr_idx_q, IDX_IRQ_CONFIG);

   // Timer A mode and counting.
   wire rx_sel = ta_ctrl_q[TA_RX_SEL_BIT];
   wire tx_sel = ta_ctrl_q[TA_TX_SEL_BIT];
   wire baud_mode = rx_sel || tx_sel;
   wire ta_run = ta_ctrl_q[TA_RUN_BIT];
   wire ta_ovf = ta_run && at_max(ta_count_q);
   wire ta_flag_set = ta_ovf && !baud_mode;

   // Timer B clock source, prescaler and counting.
   wire [3:0] osc_opt = cfg_q[CFG_OSC_LSB +: 4];
   wire lf_ok = osc_valid(osc_opt);
   wire [1:0] tb_clk_sel = tb_ctrl_q[TB_CLK_LSB +: 2];
   wire tb_sys_tick = (tb_clk_sel == TB_CLK_SYS) && !POWER_DOWN;
   wire tb_lf_tick = (tb_clk_sel == TB_CLK_LF) && lf_ok && LF_TICK;
   wire tb_run = tb_ctrl_q[TB_RUN_BIT];
   wire tb_src_tick = tb_run && (tb_sys_tick || tb_lf_tick);
   wire tb_tick;
   wire tb_ovf = tb_tick && at_max(tb_count_q);

   tick_prescaler u_prescaler (
      .clk(CLK),
      .nrst(NRST),
      .ce(CE),
      .tick_in(tb_src_tick),
      .sel(tb_ctrl_q[TB_PS_LSB +: 2]),
      .tick_out(tb_tick)
   );

   // Timer A control: set of the flag wins over a software clear.
   always_comb begin
      ta_ctrl_d = ta_ctrl_q;
      if (wr_ta_ctrl) begin
         ta_ctrl_d = wdata;
      end
      if (ta_flag_set) begin
         ta_ctrl_d[TA_FLAG_BIT] = 1'b1;
      end
   end

   always_comb begin
      ta_reload_d = ta_reload_q;
      if (wr_ta_rl) begin
         ta_reload_d[7:0] = wdata;
      end
      if (wr_ta_rh) begin
         ta_reload_d[15:8] = wdata;
      end
   end

   always_comb begin
      ta_count_d = ta_count_q;
      if (ta_ovf) begin
         ta_count_d = ta_reload_q;
      end else if (ta_run) begin
         ta_count_d = inc16(ta_count_q);
      end
      if (wr_ta_cl) begin
         ta_count_d[7:0] = wdata;
      end
      if (wr_ta_ch) begin
         ta_count_d[15:8] = wdata;
      end
   end

   // Timer B control: overflow set wins over acknowledge or software clear.
   always_comb begin
      tb_ctrl_d = tb_ctrl_q;
      if (wr_tb_ctrl) begin
         tb_ctrl_d = wdata & TB_CONTROL_MASK;
      end
      if (TIMER_B_ACK) begin
         tb_ctrl_d[TB_FLAG_BIT] = 1'b0;
      end
      if (tb_ovf) begin
         tb_ctrl_d[TB_FLAG_BIT] = 1'b1;
      end
   end

   always_comb begin
      tb_reload_d = tb_reload_q;
      if (wr_tb_lo) begin
         tb_reload_d[7:0] = wdata;
      end
      if (wr_tb_hi) begin
         tb_reload_d[15:8] = wdata;
      end
   end

   always_comb begin
      tb_count_d = tb_count_q;
      if (tb_ovf) begin
         tb_count_d = tb_reload_q;
      end else if (tb_tick) begin
         tb_count_d = inc16(tb_count_q);
      end
      if (wr_tb_hi) begin
         tb_count_d = {wdata, tb_reload_q[7:0]};
      end
   end

   // Mode, read-back select and configuration registers.
   always_comb begin
      ta_mode_d = ta_mode_q;
      if (wr_ta_mode) begin
         ta_mode_d = wdata[1:0] & TA_MODE_MASK;
      end
   end

   always_comb begin
      tb_readback_d = tb_readback_q;
      if (wr_tb_rb) begin
         tb_readback_d = wdata[0];
      end
   end

   always_comb begin
      cfg_d = cfg_q;
      if (wr_cfg) begin
         cfg_d = (wdata & CFG_MASK) | {4'h0, wdata[CFG_OSC_LSB +: 4]};
      end
   end

   // Read data multiplexer.
   wire [15:0] tb_view = tb_readback_q ? tb_reload_q : tb_count_q;
   wire [7:0] rd_byte =
      hit(addr_idx, IDX_TA_CONTROL) ? ta_ctrl_q :
      hit(addr_idx, IDX_TA_MODE) ? {6'h00, ta_mode_q} :
      hit(addr_idx, IDX_TA_RELOAD_LOW) ? ta_reload_q[7:0] :
      hit(addr_idx, IDX_TA_RELOAD_HIGH) ? ta_reload_q[15:8] :
      hit(addr_idx, IDX_TA_COUNT_LOW) ? ta_count_q[7:0] :
      hit(addr_idx, IDX_TA_COUNT_HIGH) ? ta_count_q[15:8] :
      hit(addr_idx, IDX_TB_CONTROL) ? tb_ctrl_q :
      hit(addr_idx, IDX_TB_READBACK) ? {7'h00, tb_readback_q} :
      hit(addr_idx, IDX_TB_LOW) ? tb_view[7:0] :
      hit(addr_idx, IDX_TB_HIGH) ? tb_view[15:8] :
      hit(addr_idx, IDX_IRQ_CONFIG) ? cfg_q : 8'h00;

   // Read data is captured in the address phase and stands for the data phase.
   always_comb begin
      hrdata_d = hrdata_q;
      if (addr_phase && !HWRITE) begin
         hrdata_d = {24'h00_0000, rd_byte};
      end
   end

   // Interrupt requests and baud ticks.
   wire ta_irq_d = irq_req(cfg_q, CFG_TA_IE_BIT, ta_ctrl_q[TA_FLAG_BIT]);
   wire tb_irq_d = irq_req(cfg_q, CFG_TB_IE_BIT, tb_ctrl_q[TB_FLAG_BIT]);
   wire rx_tick_d = ta_ovf && rx_sel;
   wire tx_tick_d = ta_ovf && tx_sel;

   // Bus slave state.
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         wr_pend_q <= 1'b0;
         wr_idx_q <= 8'h00;
         hrdata_q <= 32'h0000_0000;
      end else if (CE) begin
         wr_pend_q <= addr_phase && HWRITE;
         wr_idx_q <= addr_idx;
         hrdata_q <= hrdata_d;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end else begin
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end
   end

   // Timer A state.
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         ta_ctrl_q <= 8'h00;
         ta_mode_q <= 2'h0;
         ta_reload_q <= 16'h0000;
         ta_count_q <= 16'h0000;
      end else if (CE) begin
         ta_ctrl_q <= ta_ctrl_d;
         ta_mode_q <= ta_mode_d;
         ta_reload_q <= ta_reload_d;
         ta_count_q <= ta_count_d;
      end
   end

   // Timer B and configuration state.
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         tb_ctrl_q <= 8'h00;
         tb_reload_q <= 16'h0000;
         tb_count_q <= 16'h0000;
         tb_readback_q <= 1'b0;
         cfg_q <= 8'h00;
      end else if (CE) begin
         tb_ctrl_q <= tb_ctrl_d;
         tb_reload_q <= tb_reload_d;
         tb_count_q <= tb_count_d;
         tb_readback_q <= tb_readback_d;
         cfg_q <= cfg_d;
      end
   end

   // Output flops.
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         ta_irq_q <= 1'b0;
         tb_irq_q <= 1'b0;
         rx_tick_q <= 1'b0;
         tx_tick_q <= 1'b0;
      end else if (CE) begin
         ta_irq_q <= ta_irq_d;
         tb_irq_q <= tb_irq_d;
         rx_tick_q <= rx_tick_d;
         tx_tick_q <= tx_tick_d;
      end
   end

   assign HREADYOUT = hreadyout_q;
   assign HRDATA = hrdata_q;
   assign HRESP = hresp_q;
   assign TIMER_A_IRQ = ta_irq_q;
   assign TIMER_B_IRQ = tb_irq_q;
   assign RX_BAUD_TICK = rx_tick_q;
   assign TX_BAUD_TICK = tx_tick_q;
endmodule : dual_reload_timer_pair

// ---- tb/timer_pair_assertions.sv ----
`timescale 1ns/10ps
module timer_pair_assertions
   import timer_pair_pkg::*;
(
   input wire logic CLK,
   input wire logic NRST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   input wire logic TIMER_B_ACK,
   input wire logic TIMER_A_IRQ,
   input wire logic TIMER_B_IRQ,
   input wire logic RX_BAUD_TICK,
   input wire logic TX_BAUD_TICK
);
   logic wr_a;
   logic pend_q;
   logic [7:0] idx_q, cfg_q, ctl_q;
   assign wr_a = HSEL && HREADY && HTRANS == HTRANS_NONSEQ && HWRITE;
   // Shadow copies of the written interrupt configuration and timer A control.
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         pend_q <= 1'b0;
         idx_q <= 8'h00;
         cfg_q <= 8'h00;
         ctl_q <= 8'h00;
      end else begin
         pend_q <= wr_a;
         idx_q <= HADDR[9:2];
         if (pend_q && idx_q == IDX_IRQ_CONFIG) cfg_q <= HWDATA[7:0];
         if (pend_q && idx_q == IDX_TA_CONTROL) ctl_q <= HWDATA[7:0];
      end
   end
   default clocking @(posedge CLK);
   endclocking
   default disable iff (!NRST);
   property p_ready;
      HREADYOUT;
   endproperty
   a_ready: assert property (p_ready) else $error("HREADYOUT low");
   property p_okay;
      !HRESP;
   endproperty
   a_okay: assert property (p_okay) else $error("HRESP not OKAY");
   property p_ta_en;
      TIMER_A_IRQ |-> $past(cfg_q[CFG_GLOBAL_BIT] && cfg_q[CFG_TA_IE_BIT]);
   endproperty
   a_ta_en: assert property (p_ta_en) else $error("timer A irq without enables");
   property p_tb_en;
      TIMER_B_IRQ |-> $past(cfg_q[CFG_GLOBAL_BIT] && cfg_q[CFG_TB_IE_BIT]);
   endproperty
   a_tb_en: assert property (p_tb_en) else $error("timer B irq without enables");
   property p_ta_fall;
      $fell(TIMER_A_IRQ) |-> $past(wr_a, 2) || $past(wr_a, 3) || $past(wr_a, 4);
   endproperty
   a_ta_fall: assert property (p_ta_fall) else $error("timer A irq dropped alone");
   property p_tb_fall;
      $fell(TIMER_B_IRQ) |-> $past(TIMER_B_ACK, 2) || $past(TIMER_B_ACK, 3)
         || $past(wr_a, 3) || $past(wr_a, 4);
   endproperty
   a_tb_fall: assert property (p_tb_fall) else $error("timer B irq dropped alone");
   property p_rx;
      RX_BAUD_TICK |-> $past(ctl_q[TA_RX_SEL_BIT]) || $past(ctl_q[TA_RX_SEL_BIT], 2);
   endproperty
   a_rx: assert property (p_rx) else $error("receive tick unselected");
   property p_tx;
      TX_BAUD_TICK |-> $past(ctl_q[TA_TX_SEL_BIT]) || $past(ctl_q[TA_TX_SEL_BIT], 2);
   endproperty
   a_tx: assert property (p_tx) else $error("transmit tick unselected");
endmodule : timer_pair_assertions

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
module tb_top
   import timer_pair_pkg::*;
;
   logic CLK = 1'b0, NRST = 1'b0, CE = 1'b1, HSEL = 1'b0, HWRITE = 1'b0;
   logic POWER_DOWN = 1'b0, LF_TICK = 1'b0, TIMER_B_ACK = 1'b0;
   logic [31:0] HADDR = 32'h0, HWDATA = 32'h0;
   logic [1:0] HTRANS = 2'h0;
   logic [2:0] HSIZE = 3'h2;
   logic HREADY, HREADYOUT, HRESP, TIMER_A_IRQ, TIMER_B_IRQ, RX_BAUD_TICK, TX_BAUD_TICK;
   logic [31:0] HRDATA;
   logic [7:0] rv, hb;
   int n_mismatch = 0, tests_run = 0, t, p, e;
   logic [7:0] regs [11] = '{IDX_TB_CONTROL, IDX_TB_READBACK, IDX_TB_LOW, IDX_TB_HIGH,
      IDX_IRQ_CONFIG, IDX_TA_CONTROL, IDX_TA_MODE, IDX_TA_RELOAD_LOW, IDX_TA_RELOAD_HIGH,
      IDX_TA_COUNT_LOW, IDX_TA_COUNT_HIGH};
   int sh [4] = '{0, 3, 6, 8};
   logic [7:0] cf [8] = '{8'h00, 8'h0a, 8'h0d, 8'h03, 8'h06, 8'h0a, 8'h0a, 8'h0a};
   logic [1:0] sl [8] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h0, 2'h1, 2'h3};
   logic pd [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
   logic [7:0] ex [8] = '{8'h00, 8'h05, 8'h05, 8'h05, 8'h05, 8'h00, 8'h00, 8'h00};
   assign HREADY = HREADYOUT;
   dual_reload_timer_pair DUT (.CLK(CLK), .NRST(NRST), .CE(CE), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
      .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP), .POWER_DOWN(POWER_DOWN),
      .LF_TICK(LF_TICK), .TIMER_B_ACK(TIMER_B_ACK), .TIMER_A_IRQ(TIMER_A_IRQ),
      .TIMER_B_IRQ(TIMER_B_IRQ), .RX_BAUD_TICK(RX_BAUD_TICK), .TX_BAUD_TICK(TX_BAUD_TICK));
   initial begin
      forever #12.5 CLK = ~CLK;
   end
   task automatic wrap_up;
      if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] x);
      tests_run++;
      if (s !== x) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", nm, x, s);
      end
   endtask : chk
   task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d);
      HSEL <= 1'b1;
      HTRANS <= HTRANS_NONSEQ;
      HWRITE <= w;
      HADDR <= {22'h0, idx, 2'b00};
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= {24'h0, d};
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      rv = HRDATA[7:0];
   endtask : bus
   task automatic rc(input string nm, input logic [7:0] idx, input logic [7:0] x);
      bus(idx, 1'b0, 8'h00);
      chk(nm, {8'h00, rv}, {8'h00, x});
   endtask : rc
   task automatic wt(input logic b);
      t = 0;
      while ((b ? TIMER_B_IRQ : TIMER_A_IRQ) !== 1'b1 && t < 100) begin
         @(posedge CLK);
         t++;
      end
   endtask : wt
   task automatic tick_gap(input logic rx);
      t = 0;
      while ((rx ? RX_BAUD_TICK : TX_BAUD_TICK) !== 1'b1 && t < 100) begin
         @(posedge CLK);
         t++;
      end
      p = 0;
      do begin
         @(posedge CLK);
         p++;
      end while ((rx ? RX_BAUD_TICK : TX_BAUD_TICK) !== 1'b1 && p < 100);
   endtask : tick_gap
   initial begin
      repeat (12) @(posedge CLK);
      NRST <= 1'b1;
      @(posedge CLK);
      foreach (regs[i]) rc("reset value", regs[i], 8'h00);
      bus(8'h00, 1'b1, 8'h55);
      rc("unmapped", 8'h00, 8'h00);
      bus(IDX_TA_MODE, 1'b1, 8'h00);
      bus(IDX_TA_COUNT_LOW, 1'b1, 8'h10);
      bus(IDX_TA_CONTROL, 1'b1, 8'h04);
      bus(IDX_TA_CONTROL, 1'b1, 8'h00);
      repeat (20) @(posedge CLK);
      rc("count two edges", IDX_TA_COUNT_LOW, 8'h12);
      bus(IDX_TA_CONTROL, 1'b1, 8'h04);
      CE <= 1'b0;
      repeat (10) @(posedge CLK);
      CE <= 1'b1;
      bus(IDX_TA_CONTROL, 1'b1, 8'h00);
      rc("clock enable freeze", IDX_TA_COUNT_LOW, 8'h14);
      bus(IDX_TA_RELOAD_LOW, 1'b1, 8'h34);
      bus(IDX_TA_RELOAD_HIGH, 1'b1, 8'h12);
      bus(IDX_TA_COUNT_LOW, 1'b1, 8'hfa);
      bus(IDX_TA_COUNT_HIGH, 1'b1, 8'hff);
      bus(IDX_IRQ_CONFIG, 1'b1, 8'ha0);
      bus(IDX_TA_CONTROL, 1'b1, 8'h04);
      wt(1'b0);
      chk("ta irq", {15'h0, TIMER_A_IRQ}, 16'h1);
      repeat (30) @(posedge CLK);
      bus(IDX_TA_CONTROL, 1'b1, 8'h80);
      chk("ta irq held", {15'h0, TIMER_A_IRQ}, 16'h1);
      rc("ta reload high", IDX_TA_COUNT_HIGH, 8'h12);
      rc("ta flag", IDX_TA_CONTROL, 8'h80);
      bus(IDX_TA_CONTROL, 1'b1, 8'h00);
      repeat (3) @(posedge CLK);
      chk("ta cleared", {15'h0, TIMER_A_IRQ}, 16'h0);
      bus(IDX_TA_CONTROL, 1'b1, 8'h80);
      repeat (3) @(posedge CLK);
      chk("ta soft set", {15'h0, TIMER_A_IRQ}, 16'h1);
      bus(IDX_IRQ_CONFIG, 1'b1, 8'h20);
      repeat (3) @(posedge CLK);
      chk("ta no global", {15'h0, TIMER_A_IRQ}, 16'h0);
      bus(IDX_TA_CONTROL, 1'b1, 8'h00);
      bus(IDX_IRQ_CONFIG, 1'b1, 8'ha0);
      bus(IDX_TA_RELOAD_LOW, 1'b1, 8'hfc);
      bus(IDX_TA_RELOAD_HIGH, 1'b1, 8'hff);
      bus(IDX_TA_COUNT_LOW, 1'b1, 8'hfc);
      bus(IDX_TA_COUNT_HIGH, 1'b1, 8'hff);
      bus(IDX_TA_CONTROL, 1'b1, 8'h24);
      tick_gap(1'b1);
      chk("rx period", 16'(p), 16'(32'h10000 - 32'hfffc));
      bus(IDX_TA_CONTROL, 1'b1, 8'h14);
      tick_gap(1'b0);
      chk("tx period", 16'(p), 16'(32'h10000 - 32'hfffc));
      chk("baud no irq", {15'h0, TIMER_A_IRQ}, 16'h0);
      bus(IDX_TA_CONTROL, 1'b1, 8'h10);
      rc("baud no flag", IDX_TA_CONTROL, 8'h10);
      bus(IDX_TA_CONTROL, 1'b1, 8'h00);
      bus(IDX_TB_LOW, 1'b1, 8'hf0);
      bus(IDX_TB_HIGH, 1'b1, 8'hff);
      rc("tb high", IDX_TB_HIGH, 8'hff);
      rc("tb low", IDX_TB_LOW, 8'hf0);
      bus(IDX_TB_READBACK, 1'b1, 8'h01);
      bus(IDX_TB_LOW, 1'b1, 8'h22);
      rc("tb reload", IDX_TB_LOW, 8'h22);
      bus(IDX_TB_READBACK, 1'b1, 8'h00);
      rc("tb live", IDX_TB_LOW, 8'hf0);
      bus(IDX_IRQ_CONFIG, 1'b1, 8'h88);
      bus(IDX_TB_CONTROL, 1'b1, 8'h04);
      wt(1'b1);
      chk("tb irq", {15'h0, TIMER_B_IRQ}, 16'h1);
      bus(IDX_TB_CONTROL, 1'b1, 8'h80);
      rc("tb reloaded", IDX_TB_HIGH, 8'hff);
      rc("tb flag", IDX_TB_CONTROL, 8'h80);
      TIMER_B_ACK <= 1'b1;
      @(posedge CLK);
      TIMER_B_ACK <= 1'b0;
      repeat (3) @(posedge CLK);
      chk("tb ack", {15'h0, TIMER_B_IRQ}, 16'h0);
      for (int i = 0; i < 4; i++) begin
         bus(IDX_TB_LOW, 1'b1, 8'h00);
         bus(IDX_TB_HIGH, 1'b1, 8'h00);
         bus(IDX_TB_CONTROL, 1'b1, {2'b00, 2'(i), 4'h4});
         repeat (1024) @(posedge CLK);
         bus(IDX_TB_CONTROL, 1'b1, 8'h00);
         bus(IDX_TB_HIGH, 1'b0, 8'h00);
         hb = rv;
         bus(IDX_TB_LOW, 1'b0, 8'h00);
         p = int'({hb, rv});
         e = 1026 >> sh[i];
         chk("prescale", {15'h0, p + 2 >= e && p <= e + 2}, 16'h1);
      end
      foreach (cf[i]) begin
         bus(IDX_IRQ_CONFIG, 1'b1, cf[i]);
         bus(IDX_TB_LOW, 1'b1, 8'h00);
         bus(IDX_TB_HIGH, 1'b1, 8'h00);
         POWER_DOWN <= pd[i];
         bus(IDX_TB_CONTROL, 1'b1, {6'h01, sl[i]});
         repeat (5) begin
            LF_TICK <= 1'b1;
            @(posedge CLK);
            LF_TICK <= 1'b0;
            repeat (3) @(posedge CLK);
         end
         bus(IDX_TB_CONTROL, 1'b1, 8'h00);
         POWER_DOWN <= 1'b0;
         rc("clock source", IDX_TB_LOW, ex[i]);
      end
      wrap_up();
   end
   initial begin
      #(25 * 20000);
      n_mismatch++;
      wrap_up();
   end
endmodule : tb_top
bind dual_reload_timer_pair timer_pair_assertions u_chk (.CLK(CLK), .NRST(NRST),
   .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA),
   .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TIMER_B_ACK(TIMER_B_ACK),
   .TIMER_A_IRQ(TIMER_A_IRQ), .TIMER_B_IRQ(TIMER_B_IRQ), .RX_BAUD_TICK(RX_BAUD_TICK),
   .TX_BAUD_TICK(TX_BAUD_TICK));
